// [common/eba_defines.svh]
`ifndef EBA_DEFINES_SVH
`define EBA_DEFINES_SVH
`define EBA_STYLE_HOLD   1'b0
`define EBA_STYLE_REQGNT 1'b1
`define EBA_BE_NONE      4'hF
`define EBA_BE_ALL       4'h0
`define EBA_LANE_BITS    8
`define EBA_ADDR_HI      17
`define EBA_STROBE_NS    100
`define EBA_CLK_NS       50
`define EBA_STROBE_CYC   ((`EBA_STROBE_NS + `EBA_CLK_NS - 1) / `EBA_CLK_NS)
`define EBA_WAIT_W       4
`endif

// [common/eba_pkg.sv]
package eba_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ACK,
    ST_ADDR,
    ST_DATA,
    ST_END,
    ST_REL
  } eba_state_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be_n;
  } eba_req_t;

  typedef struct packed {
    logic [31:0] ad_o;
    logic        ad_oe_n;
    logic [3:0]  be_n;
    logic        be_oe_n;
    logic        rd_n;
    logic        wr_n;
    logic        ale_n;
    logic        ds_n;
    logic        as_n;
    logic        rnw;
    logic        strb_oe_n;
  } eba_pins_t;
endpackage : eba_pkg

// [rtl/eba_arbiter_port.sv]
// Function
// - all bus lines and strobes float before requesting and after release
// - hold style: raise active-high ownership request when access pending
// - hold style: stall, do not drive while grant is low
// - hold style: grant high means bus owned, access proceeds
// - once owner, drive address/data, byte enables and strobes
// - hold style: drop request after access, then float lines
// - request/grant style: drive active-low request low when access pending
// - request/grant style: hold access while active-low grant is high
// - after grant and acknowledge idle, assert acknowledge then drive bus
// - withdraw request shortly after cycle starts, acknowledge still held
// - after cycle, release acknowledge then float bus outputs
// - peripherals use low address lines and four byte enables
// - multiplexed: each peripheral uses its own 8-bit lane
// - multiplexed wiring: no 4-byte transfer in one access
// - configuration input selects hold style or request/grant style
`include "eba_defines.svh"

module eba_arbiter_port (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              host_style_select,
  input  wire logic              mux_wiring,
  input  wire logic              acc_valid,
  input  wire eba_pkg::eba_req_t acc_req,
  output logic                   acc_ready,
  output logic                   acc_done,
  output logic [31:0]            acc_rdata,
  output logic                   acc_error,
  input  wire logic              bus_ownership_grant,
  input  wire logic              ownership_grant_n,
  input  wire logic              grant_acknowledge_n_i,
  output logic                   bus_ownership_request,
  output logic                   ownership_request_n,
  output logic                   grant_acknowledge_n_o,
  output logic                   grant_acknowledge_n_oe_n,
  input  wire logic [31:0]       ext_addr_data_i,
  output eba_pkg::eba_pins_t     pins
);
  typedef struct packed {
    eba_pkg::eba_state_t         st;
    logic                        style;
    eba_pkg::eba_req_t           req;
    logic [`EBA_WAIT_W-1:0]      cnt;
    logic [1:0]                  hg_s;
    logic [1:0]                  bg_s;
    logic [1:0]                  ack_s;
    logic                        hold;
    logic                        br_n;
    logic                        gack_n;
    logic                        gack_oe_n;
    logic                        ready;
    logic                        done;
    logic                        err;
    logic [31:0]                 rdata;
    eba_pkg::eba_pins_t          pins;
  } eba_state_s_t;

  eba_state_s_t s_r;
  eba_state_s_t s_nxt;

  function automatic eba_pkg::eba_pins_t float_pins();
    eba_pkg::eba_pins_t p;
    p           = '0;
    p.ad_oe_n   = 1'b1;
    p.be_n      = `EBA_BE_NONE;
    p.be_oe_n   = 1'b1;
    p.rd_n      = 1'b1;
    p.wr_n      = 1'b1;
    p.ale_n     = 1'b1;
    p.ds_n      = 1'b1;
    p.as_n      = 1'b1;
    p.rnw       = 1'b1;
    p.strb_oe_n = 1'b1;
    return p;
  endfunction : float_pins

  logic        granted;
  logic        ack_free;
  logic [31:0] lane_rdata;

  // unselected byte lanes read back as zero
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_rdata[g*`EBA_LANE_BITS +: `EBA_LANE_BITS] =
      s_r.req.be_n[g] ? 8'h00 : ext_addr_data_i[g*`EBA_LANE_BITS +: `EBA_LANE_BITS];
  end

  always_comb begin
    granted  = (s_r.style == `EBA_STYLE_HOLD) ? s_r.hg_s[1] : ~s_r.bg_s[1];
    ack_free = s_r.ack_s[1];
    s_nxt    = s_r;
    // second stage reads only the first
    s_nxt.hg_s  = {s_r.hg_s[0], bus_ownership_grant};
    s_nxt.bg_s  = {s_r.bg_s[0], ownership_grant_n};
    s_nxt.ack_s = {s_r.ack_s[0], grant_acknowledge_n_i};
    s_nxt.done  = 1'b0;
    s_nxt.err   = 1'b0;
    s_nxt.ready = 1'b0;
    case (s_r.st)
      eba_pkg::ST_IDLE: begin
        s_nxt.pins  = float_pins();
        s_nxt.style = host_style_select;
        s_nxt.ready = 1'b1;
        if (acc_valid && s_r.ready) begin
          s_nxt.ready = 1'b0;
          if (mux_wiring && acc_req.be_n == `EBA_BE_ALL) begin
            s_nxt.err  = 1'b1;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.req = acc_req;
            s_nxt.st  = eba_pkg::ST_REQ;
            if (host_style_select == `EBA_STYLE_HOLD) begin
              s_nxt.hold = 1'b1;
            end else begin
              s_nxt.br_n = 1'b0;
            end
          end
        end
      end
      eba_pkg::ST_REQ: begin
        // request stays raised while waiting
        if (granted) begin
          if (s_r.style == `EBA_STYLE_HOLD) begin
            s_nxt.st = eba_pkg::ST_ADDR;
          end else begin
            s_nxt.st = eba_pkg::ST_ACK;
          end
        end
      end
      eba_pkg::ST_ACK: begin
        if (ack_free) begin
          s_nxt.gack_n    = 1'b0;
          s_nxt.gack_oe_n = 1'b0;
          s_nxt.st        = eba_pkg::ST_ADDR;
        end
      end
      eba_pkg::ST_ADDR: begin
        s_nxt.pins.ad_o      = s_r.req.addr;
        s_nxt.pins.ad_oe_n   = 1'b0;
        s_nxt.pins.be_n      = s_r.req.be_n;
        s_nxt.pins.be_oe_n   = 1'b0;
        s_nxt.pins.strb_oe_n = 1'b0;
        s_nxt.pins.rnw       = ~s_r.req.write;
        if (s_r.style == `EBA_STYLE_HOLD) begin
          s_nxt.pins.ale_n = 1'b0;
        end else begin
          s_nxt.pins.as_n = 1'b0;
        end
        s_nxt.cnt = '0;
        s_nxt.st  = eba_pkg::ST_DATA;
      end
      eba_pkg::ST_DATA: begin
        s_nxt.br_n = 1'b1;
        s_nxt.pins.ad_o    = s_r.req.write ? s_r.req.wdata : '0;
        s_nxt.pins.ad_oe_n = ~s_r.req.write;
        if (s_r.style == `EBA_STYLE_HOLD) begin
          s_nxt.pins.rd_n = s_r.req.write;
          s_nxt.pins.wr_n = ~s_r.req.write;
        end else begin
          s_nxt.pins.ds_n = 1'b0;
        end
        s_nxt.cnt = s_r.cnt + `EBA_WAIT_W'(1);
        if (s_r.cnt == `EBA_WAIT_W'(`EBA_STROBE_CYC)) begin
          s_nxt.rdata = lane_rdata;
          s_nxt.st    = eba_pkg::ST_END;
        end
      end
      eba_pkg::ST_END: begin
        s_nxt.pins.rd_n  = 1'b1;
        s_nxt.pins.wr_n  = 1'b1;
        s_nxt.pins.ds_n  = 1'b1;
        s_nxt.pins.ale_n = 1'b1;
        s_nxt.pins.as_n  = 1'b1;
        s_nxt.hold       = 1'b0;
        s_nxt.gack_n     = 1'b1;
        s_nxt.st         = eba_pkg::ST_REL;
      end
      eba_pkg::ST_REL: begin
        s_nxt.pins      = float_pins();
        s_nxt.gack_oe_n = 1'b1;
        s_nxt.done      = 1'b1;
        s_nxt.st        = eba_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = eba_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r           <= '0;
      s_r.st        <= eba_pkg::ST_IDLE;
      s_r.pins      <= float_pins();
      s_r.br_n      <= 1'b1;
      s_r.gack_n    <= 1'b1;
      s_r.gack_oe_n <= 1'b1;
      s_r.ack_s     <= 2'h3;
      s_r.bg_s      <= 2'h3;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc_ready                = s_r.ready;
  assign acc_done                 = s_r.done;
  assign acc_rdata                = s_r.rdata;
  assign acc_error                = s_r.err;
  assign bus_ownership_request    = s_r.hold;
  assign ownership_request_n      = s_r.br_n;
  assign grant_acknowledge_n_o    = s_r.gack_n;
  assign grant_acknowledge_n_oe_n = s_r.gack_oe_n;
  assign pins                     = s_r.pins;
endmodule : eba_arbiter_port

// [bench/eba_checker.sv]
module eba_checker (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               host_style_select,
  input wire logic               mux_wiring,
  input wire logic               acc_valid,
  input wire eba_pkg::eba_req_t  acc_req,
  input wire logic               acc_ready,
  input wire logic               acc_done,
  input wire logic               acc_error,
  input wire logic               bus_ownership_grant,
  input wire logic               ownership_grant_n,
  input wire logic               grant_acknowledge_n_i,
  input wire logic               bus_ownership_request,
  input wire logic               ownership_request_n,
  input wire logic               grant_acknowledge_n_o,
  input wire logic               grant_acknowledge_n_oe_n,
  input wire eba_pkg::eba_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bad;
  logic take;
  assign bad = mux_wiring && acc_req.be_n == 4'h0;
  assign take = acc_valid && acc_ready && !bad;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  idle_float_a: assert property (
    acc_ready |-> pins.ad_oe_n && pins.be_oe_n && pins.strb_oe_n) else $error("idle drive");
  hold_req_a: assert property (
    take && !host_style_select |-> ##[1:2] bus_ownership_request) else $error("no hold req");
  rg_req_a: assert property (
    take && host_style_select |-> ##[1:2] !ownership_request_n) else $error("no req");
  hold_wait_a: assert property (
    $fell(pins.be_oe_n) && !host_style_select |-> $past(bus_ownership_grant, 2))
    else $error("drive w/o grant");
  hold_end_a: assert property (
    $fell(bus_ownership_request) |-> !$past(pins.strb_oe_n) ##1 (pins.ad_oe_n && pins.be_oe_n))
    else $error("hold release");
  rg_ack_a: assert property (
    $fell(grant_acknowledge_n_o | grant_acknowledge_n_oe_n)
    |-> !$past(ownership_grant_n, 3) && $past(grant_acknowledge_n_i, 3)) else $error("ack early");
  rg_drop_a: assert property (
    $rose(ownership_request_n) |-> !grant_acknowledge_n_oe_n && !grant_acknowledge_n_o
    && !pins.ds_n) else $error("req drop");
  rg_rel_a: assert property (
    $rose(grant_acknowledge_n_o) |-> ##1 (pins.ad_oe_n && pins.strb_oe_n)) else $error("rel");
  refuse_a: assert property (
    acc_valid && acc_ready && bad |=> acc_done && acc_error && pins.be_oe_n) else $error("refuse");
endmodule : eba_checker

bind eba_arbiter_port eba_checker eba_checker_inst (.clk(clk), .nrst(nrst),
  .host_style_select(host_style_select), .mux_wiring(mux_wiring), .acc_valid(acc_valid),
  .acc_req(acc_req), .acc_ready(acc_ready), .acc_done(acc_done), .acc_error(acc_error),
  .bus_ownership_grant(bus_ownership_grant), .ownership_grant_n(ownership_grant_n),
  .grant_acknowledge_n_i(grant_acknowledge_n_i), .bus_ownership_request(bus_ownership_request),
  .ownership_request_n(ownership_request_n), .grant_acknowledge_n_o(grant_acknowledge_n_o),
  .grant_acknowledge_n_oe_n(grant_acknowledge_n_oe_n), .pins(pins));

// [bench/eba_arb_model.sv]
module eba_arb_model #(
  parameter logic [31:0] RDATA = 32'h0
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               hold_req,
  input wire logic               req_n,
  input wire logic [3:0]         lag,
  input wire eba_pkg::eba_pins_t pins,
  output logic                   hold_gnt,
  output logic                   gnt_n,
  output logic [31:0]            rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    cnt_r <= (nrst && (hold_req || !req_n)) ? cnt_r + {3'h0, cnt_r != 4'hF} : 4'h0;
    hold_gnt <= nrst && hold_req && cnt_r >= lag;
    gnt_n <= !(nrst && !req_n && cnt_r >= lag);
  end
  assign rd_data = (!pins.rd_n || (!pins.ds_n && pins.rnw)) ? RDATA : ~RDATA;
endmodule : eba_arb_model

// [bench/test_eba_arbiter_port.sv]
module test_eba_arbiter_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] AD = 32'h00023ABC;
  localparam logic [31:0] WD = 32'hA5C30F96;
  localparam logic [31:0] RD = 32'h5A3CF069;
  logic clk = 1'b0, nrst = 1'b0, sty = 1'b0, mux = 1'b0, vld = 1'b0, ack_x_n = 1'b1;
  logic [3:0] lag = 4'h0;
  eba_pkg::eba_req_t req = '0;
  eba_pkg::eba_pins_t pins;
  logic rdy, done, err, breq, rqn, gk_o, gk_oe, hgm, gnm, rw_seen;
  logic solo = 1'b0;
  logic [3:0] be_seen;
  logic [4:0] low_seen;
  logic [31:0] rdata, adi;
  wire logic hg = solo | hgm;
  wire logic gn = gnm & ~solo;
  wire logic gk_i = gk_oe ? ack_x_n : gk_o;
  int err_count = 0;
  int n_checks = 0;
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", s, e, g); end end
  always #25 clk = ~clk;
  eba_arbiter_port eba_arbiter_port_inst (.clk(clk), .nrst(nrst), .host_style_select(sty),
    .mux_wiring(mux), .acc_valid(vld), .acc_req(req), .acc_ready(rdy), .acc_done(done),
    .acc_rdata(rdata), .acc_error(err), .bus_ownership_grant(hg), .ownership_grant_n(gn),
    .grant_acknowledge_n_i(gk_i), .bus_ownership_request(breq), .ownership_request_n(rqn),
    .grant_acknowledge_n_o(gk_o), .grant_acknowledge_n_oe_n(gk_oe), .ext_addr_data_i(adi),
    .pins(pins));
  eba_arb_model #(.RDATA(RD)) eba_arb_model_inst (.clk(clk), .nrst(nrst), .hold_req(breq),
    .req_n(rqn), .lag(lag), .pins(pins), .hold_gnt(hgm), .gnt_n(gnm), .rd_data(adi));
  task automatic summarize();
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic access(input logic w, input logic [3:0] be, output logic [31:0] a);
    int n;
    a = ~AD;
    be_seen = 4'hF;
    low_seen = 5'h00;
    rw_seen = 1'b0;
    req = '{w, AD, WD, be};
    vld = 1'b1;
    for (n = 0; rdy !== 1'b1 && n < 20; n++) begin @(posedge clk); #5; end
    @(posedge clk);
    #5 vld = 1'b0;
    for (n = 0; done !== 1'b1 && n < 200; n++) begin
      if (a === ~AD && pins.ad_oe_n === 1'b0) begin
        a = pins.ad_o;
        be_seen = pins.be_n;
        rw_seen = pins.rnw;
      end
      low_seen = low_seen | ~{pins.ale_n, pins.rd_n, pins.wr_n, pins.as_n, pins.ds_n};
      @(posedge clk);
      #5;
    end
    `CHK("done", 1'b1, done)
  endtask : access
  task automatic hold_t();
    logic [31:0] a;
    access(1'b1, 4'h0, a);
    `CHK("hold addr", AD, a)
    `CHK("hold wr strobes", 5'h14, low_seen)
    `CHK("hold wr dir", 1'b0, rw_seen)
    lag = 4'h8;
    access(1'b0, 4'hC, a);
    `CHK("slow rdata", RD & 32'h0000FFFF, rdata)
    `CHK("slow lanes", 4'hC, be_seen)
    `CHK("hold rd strobes", 5'h18, low_seen)
  endtask : hold_t
  task automatic rg_t();
    logic [31:0] a;
    sty = 1'b1;
    lag = 4'h0;
    ack_x_n = 1'b0;
    fork
      access(1'b0, 4'h0, a);
      begin repeat (6) @(posedge clk); #5 ack_x_n = 1'b1; end
    join
    `CHK("rg addr", AD, a)
    `CHK("rg rdata", RD, rdata)
    `CHK("rg strobes", 5'h03, low_seen)
    `CHK("rg dir", 1'b1, rw_seen)
  endtask : rg_t
  task automatic mux_t();
    logic [31:0] a;
    mux = 1'b1;
    access(1'b1, 4'h0, a);
    `CHK("mux err", 1'b1, err)
    `CHK("mux float", ~AD, a)
    `CHK("mux quiet", 5'h00, low_seen)
    access(1'b0, 4'hE, a);
    `CHK("lane rdata", RD & 32'h000000FF, rdata)
    `CHK("mux addr", AD, a)
    `CHK("bank lanes", 4'hE, be_seen)
  endtask : mux_t
  task automatic noarb_t();
    logic [31:0] a;
    solo = 1'b1;
    mux = 1'b0;
    sty = 1'b0;
    lag = 4'hF;
    access(1'b1, 4'h3, a);
    `CHK("tied hold", 5'h14, low_seen)
    sty = 1'b1;
    access(1'b0, 4'h0, a);
    `CHK("tied grant", RD, rdata)
    solo = 1'b0;
  endtask : noarb_t
  initial begin
    repeat (3) @(posedge clk);
    #5 nrst = 1'b1;
    hold_t();
    rg_t();
    mux_t();
    noarb_t();
    summarize();
  end
  initial begin
    #(3000 * 50);
    err_count++;
    summarize();
  end
endmodule : test_eba_arbiter_port
